// file: design/wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// Register byte addresses on the APB side
`define WDT_ADDR_CTRL     12'h000
`define WDT_ADDR_CLKCFG   12'h004
`define WDT_ADDR_IRQSTAT  12'h008
`define WDT_ADDR_IRQMASK  12'h00C
`define WDT_ADDR_IRQCTRL  12'h010
`define WDT_ADDR_UNLOCK   12'h014

// Watchdog control field positions
`define WDT_BIT_RESTART   0
`define WDT_BIT_RSTEN     1
`define WDT_BIT_RSTCAUSE  2
`define WDT_BIT_IRQFLAG   3

// Clock control field positions
`define WDT_BIT_SEL_LO    6
`define WDT_BIT_SEL_HI    7

// Interrupt control field positions
`define WDT_BIT_IE_WDT    4
`define WDT_BIT_IE_GLOBAL 7

// Interrupt status bits
`define WDT_EV_TIMEOUT    0
`define WDT_EV_RESET      1

// Reset values
`define WDT_SEL_RESET     2'h0
`define WDT_CTRL_RESET    8'h00

// Interval exponents per select code
`define WDT_EXP_SEL0      17
`define WDT_EXP_SEL1      20
`define WDT_EXP_SEL2      23
`define WDT_EXP_SEL3      26

// Timing counts
`define WDT_GRACE_CLOCKS  512
`define WDT_CLK_PER_MC    4
`define WDT_RST_MCYCLES   2
`define WDT_RST_CLOCKS    (`WDT_CLK_PER_MC * `WDT_RST_MCYCLES)

`endif

// file: design/wdt_pkg.sv
package wdt_pkg;

    // Counter phases
    typedef enum logic [1:0] {
        WDT_OFF,
        WDT_COUNT,
        WDT_GRACE,
        WDT_RESET
    } wdt_state_t;

    // APB request bundle
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } wdt_apb_req_t;

endpackage : wdt_pkg

// file: design/wdt_monitor.sv
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "wdt_defs.svh"

// Overview of operation
// [RL1] Counter divides system clock continuously; here it is held at zero in the off and reset phases
// [RL2] Two-bit select picks one of four intervals
// [RL3] Select defaults to shortest interval after reset
// [RL4] Interval elapse sets interrupt flag bit 3
// [RL5] Flag set again every completed interval
// [RL6] Request needs flag, bit 4 enable, global enable
// [RL7] Flag holds until software clear or reset
// [RL8] After time-out wait 512 clocks, then reset
// [RL9] Reset lasts two machine cycles, sets cause
// [RL10] Cause flag cleared by software or power-fail
// [RL11] Enable low: cause flag never touched
// [RL12] Enable bit 1 gates reset only
// [RL13] Restart bit clears counter, self-clears
// [RL14] Interrupt and reset paths independent
// [RL15] Power-on or power-fail reset disables timer
// [RL16] Own reset restarts count, keeps running
// [RL17] Protected bits need timed-access procedure
// [RL18] Protected writes honoured only with unlock
module wdt_monitor #(
    parameter int CNT_W    = 27,
    parameter int EXP_BASE = `WDT_EXP_SEL0
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        POWER_FAIL_RESET,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Timed-access unlock pulse
    input  wire logic        TA_UNLOCK,
    // System outputs
    output logic             WDT_SYS_RESET,
    output logic             WDT_IRQ_REQ,
    output logic             IRQ
);

    // Counter must hold the longest interval, and the shortest one must outlast the grace span
    if (CNT_W < EXP_BASE + `WDT_EXP_SEL3 - `WDT_EXP_SEL0 + 1 || EXP_BASE < 10) begin : g_bad_param
        $error("CNT_W or EXP_BASE out of range");
    end

    // Interval length of a select code
    function automatic logic [CNT_W-1:0] interval_len(input logic [1:0] sel);
        logic [CNT_W-1:0] one;
        one = {{(CNT_W-1){1'b0}}, 1'b1};
        unique case (sel)
            // Codes keep their spacing; only the base exponent may be shortened
            2'h0: interval_len = one << EXP_BASE;
            2'h1: interval_len = one << (EXP_BASE + `WDT_EXP_SEL1 - `WDT_EXP_SEL0);
            2'h2: interval_len = one << (EXP_BASE + `WDT_EXP_SEL2 - `WDT_EXP_SEL0);
            2'h3: interval_len = one << (EXP_BASE + `WDT_EXP_SEL3 - `WDT_EXP_SEL0);
        endcase
    endfunction : interval_len

    wdt_pkg::wdt_apb_req_t req;                 // Bundled bus request
    wdt_pkg::wdt_state_t   state_q;             // Counter phase
    logic [CNT_W-1:0]      cnt_q;               // Clock divider count
    logic [9:0]            grace_q;             // Grace or reset-pulse count
    logic [1:0]            sel_q;               // Interval select
    logic                  rsten_q;             // Watchdog reset enable
    logic                  irqflag_q;           // Time-out flag
    logic                  cause_q;             // Reset cause flag
    logic                  ie_wdt_q;            // Individual interrupt enable
    logic                  ie_glob_q;           // Global interrupt enable
    logic [1:0]            stat_q;              // Sticky event status
    logic [1:0]            mask_q;              // Event mask
    logic                  unlock_q;            // Pending unlock window
    logic                  wr;                  // Write strobe
    logic                  rd_ok;               // Mapped address
    logic                  prot_ok;             // Protected write allowed
    logic                  restart;             // Restart request
    logic                  timeout;             // Interval elapsed this cycle
    logic                  fire;                // Grace span over, reset due
    logic                  rst_end;             // Reset pulse finishing

    assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};

    // Zero-wait slave: every access completes in its first access cycle
    assign PREADY  = 1'b1;
    assign PSLVERR = req.sel & req.enable & ~rd_ok;
    assign wr      = req.sel & req.enable & req.write & rd_ok;

    // Address decode
    always_comb begin
        unique case (req.addr)
            `WDT_ADDR_CTRL, `WDT_ADDR_CLKCFG, `WDT_ADDR_IRQSTAT,
            `WDT_ADDR_IRQMASK, `WDT_ADDR_IRQCTRL, `WDT_ADDR_UNLOCK: rd_ok = 1'b1;
            default: rd_ok = 1'b0;
        endcase
    end

    // Unlock input covers the current cycle only, a software-written unlock the one cycle after its write
    assign prot_ok = TA_UNLOCK | unlock_q; // RL18
    assign restart = wr && req.addr == `WDT_ADDR_CTRL && req.wdata[`WDT_BIT_RESTART] && prot_ok; // RL13 RL17

    // Event decode from the counter
    assign timeout = state_q == wdt_pkg::WDT_COUNT && cnt_q == interval_len(sel_q) - 1'b1; // RL2
    assign fire    = state_q == wdt_pkg::WDT_GRACE && grace_q == 10'(`WDT_GRACE_CLOCKS - 1)
                     && rsten_q && !restart; // RL8 RL12
    assign rst_end = state_q == wdt_pkg::WDT_RESET && grace_q == 10'(`WDT_RST_CLOCKS - 1);

    // Software unlock register arms protected writes for the next cycle
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            unlock_q <= 1'b0;
        end else begin
            unlock_q <= wr && req.addr == `WDT_ADDR_UNLOCK && req.wdata[0]; // RL17
        end
    end

    // Counter phases; power-fail resets halt it, own reset restarts it
    always_ff @(posedge CLK) begin
        if (!RESETN || POWER_FAIL_RESET) begin
            state_q <= wdt_pkg::WDT_OFF; // RL15
            cnt_q   <= '0;
            grace_q <= '0;
        end else if (restart) begin
            // Restart also takes the timer out of the off phase
            state_q <= wdt_pkg::WDT_COUNT; // RL13
            cnt_q   <= '0;
            grace_q <= '0;
        end else begin
            unique case (state_q)
                wdt_pkg::WDT_OFF: begin
                    cnt_q <= '0;
                end
                wdt_pkg::WDT_COUNT: begin
                    cnt_q <= timeout ? '0 : cnt_q + 1'b1; // RL1 RL5
                    if (timeout) begin
                        state_q <= wdt_pkg::WDT_GRACE;
                        grace_q <= '0;
                    end
                end
                wdt_pkg::WDT_GRACE: begin
                    // Divider keeps running through the grace span
                    cnt_q   <= cnt_q + 1'b1; // RL1
                    grace_q <= grace_q + 1'b1;
                    if (fire) begin
                        state_q <= wdt_pkg::WDT_RESET; // RL8
                        grace_q <= '0;
                    end else if (grace_q == 10'(`WDT_GRACE_CLOCKS - 1)) begin
                        state_q <= wdt_pkg::WDT_COUNT; // RL12
                    end
                end
                wdt_pkg::WDT_RESET: begin
                    grace_q <= grace_q + 1'b1;
                    cnt_q   <= '0;
                    if (rst_end) begin
                        state_q <= wdt_pkg::WDT_COUNT; // RL16
                        grace_q <= '0;
                    end
                end
            endcase
        end
    end

    // Interval select, reset to the shortest interval
    always_ff @(posedge CLK) begin
        if (!RESETN || POWER_FAIL_RESET || rst_end) begin
            sel_q <= `WDT_SEL_RESET; // RL3
        end else if (wr && req.addr == `WDT_ADDR_CLKCFG) begin
            sel_q <= req.wdata[`WDT_BIT_SEL_HI:`WDT_BIT_SEL_LO]; // RL2
        end
    end

    // Reset enable; a watchdog reset leaves it so the monitor keeps watching
    always_ff @(posedge CLK) begin
        if (!RESETN || POWER_FAIL_RESET) begin
            rsten_q <= 1'b0; // RL15
        end else if (wr && req.addr == `WDT_ADDR_CTRL && prot_ok) begin
            rsten_q <= req.wdata[`WDT_BIT_RSTEN]; // RL12 RL17
        end
    end

    // Time-out flag: set wins over a same-cycle clear
    always_ff @(posedge CLK) begin
        if (!RESETN || POWER_FAIL_RESET || rst_end) begin
            irqflag_q <= 1'b0; // RL7
        end else if (timeout) begin
            irqflag_q <= 1'b1; // RL4 RL5
        end else if (wr && req.addr == `WDT_ADDR_CTRL && prot_ok) begin
            irqflag_q <= req.wdata[`WDT_BIT_IRQFLAG]; // RL7 RL17
        end
    end

    // Cause flag: kept across system resets, cleared by power-fail or software
    always_ff @(posedge CLK) begin
        if (!RESETN || POWER_FAIL_RESET) begin
            cause_q <= 1'b0; // RL10
        end else if (fire) begin
            cause_q <= 1'b1; // RL9 RL11
        end else if (wr && req.addr == `WDT_ADDR_CTRL && !req.wdata[`WDT_BIT_RSTCAUSE]) begin
            cause_q <= 1'b0; // RL10
        end
    end

    // Individual and global enables
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ie_wdt_q  <= 1'b0;
            ie_glob_q <= 1'b0;
        end else if (wr && req.addr == `WDT_ADDR_IRQCTRL) begin
            ie_wdt_q  <= req.wdata[`WDT_BIT_IE_WDT];
            ie_glob_q <= req.wdata[`WDT_BIT_IE_GLOBAL];
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            stat_q <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == `WDT_EV_TIMEOUT && timeout) || (i == `WDT_EV_RESET && fire)) begin
                    stat_q[i] <= 1'b1;
                end else if (wr && req.addr == `WDT_ADDR_IRQSTAT && req.wdata[i]) begin
                    stat_q[i] <= 1'b0;
                end
            end
        end
    end

    // Event mask
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            mask_q <= '0;
        end else if (wr && req.addr == `WDT_ADDR_IRQMASK) begin
            mask_q <= req.wdata[1:0];
        end
    end

    // Read data registered for the access phase that follows setup
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            PRDATA <= '0;
        end else if (req.sel && !req.enable) begin
            unique case (req.addr)
                `WDT_ADDR_CTRL:    PRDATA <= {28'h0, irqflag_q, cause_q, rsten_q, 1'b0};
                `WDT_ADDR_CLKCFG:  PRDATA <= {24'h0, sel_q, 6'h00};
                `WDT_ADDR_IRQSTAT: PRDATA <= {30'h0, stat_q};
                `WDT_ADDR_IRQMASK: PRDATA <= {30'h0, mask_q};
                `WDT_ADDR_IRQCTRL: PRDATA <= {24'h0, ie_glob_q, 2'h0, ie_wdt_q, 4'h0};
                default:           PRDATA <= '0;
            endcase
        end
    end

    // Registered system outputs
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            WDT_SYS_RESET <= 1'b0;
            WDT_IRQ_REQ   <= 1'b0;
            IRQ           <= 1'b0;
        end else begin
            WDT_SYS_RESET <= state_q == wdt_pkg::WDT_RESET; // RL9 RL14
            WDT_IRQ_REQ   <= irqflag_q && ie_wdt_q && ie_glob_q; // RL6 RL14
            IRQ           <= |(stat_q & mask_q);
        end
    end

endmodule : wdt_monitor

// file: tb/wdt_monitor_chk.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"

// Port-side checks of the watchdog monitor
module wdt_monitor_chk (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        POWER_FAIL_RESET,
    // APB slave
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // System outputs
    input wire logic        WDT_SYS_RESET,
    input wire logic        WDT_IRQ_REQ,
    input wire logic        IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    logic acc;    // Access phase of a transfer
    logic mapped; // Address hits a register word
    assign acc    = PSEL && PENABLE;
    assign mapped = (PADDR <= `WDT_ADDR_UNLOCK) && (PADDR[1:0] == 2'h0);

    // Reset pulse of two machine cycles, then low
    sequence s_pulse;
        WDT_SYS_RESET [*8] ##1 !WDT_SYS_RESET;
    endsequence
    // Count restarts from zero, so no request for a while
    sequence s_quiet;
        ##2 !WDT_IRQ_REQ [*8];
    endsequence

    chk_ready_high: assert property (PREADY) else $error("pready low");
    chk_err_decode: assert property (acc |-> PSLVERR == !mapped) else $error("pslverr decode wrong");
    chk_err_quiet: assert property (!acc |-> !PSLVERR) else $error("pslverr outside access");
    chk_unmapped_zero: assert property (acc && !PWRITE && !mapped |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    chk_restart_reads0: assert property (acc && !PWRITE && PADDR == `WDT_ADDR_CTRL |-> !PRDATA[0])
        else $error("restart bit reads one");
    chk_pulse_len: assert property ($rose(WDT_SYS_RESET) |-> s_pulse)
        else $error("reset pulse length wrong");
    chk_own_restart: assert property ($fell(WDT_SYS_RESET) |-> s_quiet)
        else $error("request soon after own reset");
    chk_pf_stops: assert property (POWER_FAIL_RESET [*3] |-> !WDT_SYS_RESET && !WDT_IRQ_REQ)
        else $error("power fail did not stop timer");
    chk_reset_outs: assert property ($rose(RESETN) |-> !WDT_SYS_RESET && !IRQ && !WDT_IRQ_REQ)
        else $error("outputs not clear after reset");
endmodule : wdt_monitor_chk

bind wdt_monitor wdt_monitor_chk i_wdt_monitor_chk (.CLK(CLK), .RESETN(RESETN),
    .POWER_FAIL_RESET(POWER_FAIL_RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .WDT_SYS_RESET(WDT_SYS_RESET), .WDT_IRQ_REQ(WDT_IRQ_REQ), .IRQ(IRQ));

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"

// Self-checking bench of the watchdog monitor
module tb_top;
    logic        CLK, RESETN, POWER_FAIL_RESET;       // Clock and resets
    logic        PSEL, PENABLE, PWRITE, TA_UNLOCK;    // Bus controls
    logic [11:0] PADDR;                               // Byte address
    logic [31:0] PWDATA, PRDATA, rd;                  // Bus data, last read
    logic        PREADY, PSLVERR, err;                // Bus answer, last error
    logic        WDT_SYS_RESET, WDT_IRQ_REQ, IRQ;     // System outputs
    int          n_fail, comparisons, seed, tt, i;   // Bookkeeping
    int          cyc = 0;                            // Free cycle count
    localparam int EXP_BASE = 10;                    // Shortened base exponent keeps the run short

    // Device under test, no input tied off
    wdt_monitor #(.EXP_BASE(EXP_BASE)) i_wdt_monitor (.CLK(CLK), .RESETN(RESETN),
        .POWER_FAIL_RESET(POWER_FAIL_RESET),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TA_UNLOCK(TA_UNLOCK),
        .WDT_SYS_RESET(WDT_SYS_RESET), .WDT_IRQ_REQ(WDT_IRQ_REQ), .IRQ(IRQ));

    // 125 MHz clock
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    // Free cycle count for interval timing
    always @(posedge CLK) cyc <= cyc + 1;

    // Interval length per select code, a factor of eight apart
    function automatic int ticks(input int sel);
        return 1 << (EXP_BASE + 3 * sel);
    endfunction : ticks

    // Compare and count
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One APB transfer; answer taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic ta);
        @(posedge CLK);
        PSEL   <= 1'b1;
        PWRITE <= wr;
        PADDR  <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE   <= 1'b1;
        TA_UNLOCK <= ta;
        @(posedge CLK);
        while (PREADY !== 1'b1) begin
            @(posedge CLK);
        end
        rd  = PRDATA;
        err = PSLVERR;
        PSEL      <= 1'b0;
        PENABLE   <= 1'b0;
        TA_UNLOCK <= 1'b0;
    endtask : apb

    // Bounded wait for an output level
    task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
        int k;
        k = 0;
        while (s !== lvl && k < lim) begin
            @(posedge CLK);
            #1;
            k++;
        end
        check("wait_bound", 32'h1, k < lim);
    endtask : wait_lvl

    // Verdict, shared by main sequence and watchdog
    task automatic test_done;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        {n_fail, comparisons} = '0;
        seed = 97;
        {RESETN, POWER_FAIL_RESET, PSEL, PENABLE, PWRITE, TA_UNLOCK} = 6'h00;
        PADDR  = 12'h000;
        PWDATA = 32'h0;
        repeat (12) @(posedge CLK);
        RESETN <= 1'b1;
        apb(1'b0, `WDT_ADDR_CTRL, 32'h0, 1'b0);
        check("ctrl_reset", 32'h0, rd);
        apb(1'b0, 12'h020, 32'h0, 1'b0);
        check("unmapped_err", 32'h1, err);
        // Protected bits ignored without unlock pulse
        apb(1'b1, `WDT_ADDR_CTRL, 32'h2, 1'b0);
        apb(1'b0, `WDT_ADDR_CTRL, 32'h0, 1'b0);
        check("ctrl_locked", 32'h0, rd);
        apb(1'b0, `WDT_ADDR_CLKCFG, 32'h0, 1'b0);
        check("sel_reset", 32'h0, rd[7:6]);
        // Every select code, random other bits
        for (i = 0; i < 5; i++) begin
            apb(1'b1, `WDT_ADDR_CLKCFG, ($random(seed) & 32'hFFFFFF3F) | ((i % 4) << 6), 1'b0);
            apb(1'b0, `WDT_ADDR_CLKCFG, 32'h0, 1'b0);
            check("sel_code", i % 4, rd[7:6]);
        end
        // Shortest interval, both paths armed
        apb(1'b1, `WDT_ADDR_IRQCTRL, 32'h90, 1'b0);
        apb(1'b1, `WDT_ADDR_IRQMASK, 32'h1, 1'b0);
        apb(1'b1, `WDT_ADDR_CTRL, 32'h3, 1'b1);
        tt = cyc;
        apb(1'b0, `WDT_ADDR_CTRL, 32'h0, 1'b0);
        check("ctrl_armed", 32'h2, rd);
        wait_lvl(WDT_IRQ_REQ, 1'b1, ticks(0) + 64);
        check("timeout_len", 32'h1, (cyc - tt >= ticks(0) - 4) && (cyc - tt <= ticks(0) + 8));
        tt = cyc;
        @(posedge CLK);
        #1;
        check("irq_line", 32'h1, IRQ);
        apb(1'b0, `WDT_ADDR_CTRL, 32'h0, 1'b0);
        check("ctrl_timeout", 32'hA, rd);
        // Global enable off drops request, status line stays
        apb(1'b1, `WDT_ADDR_IRQCTRL, 32'h10, 1'b0);
        @(posedge CLK);
        #1;
        check("req_gated", 32'h0, WDT_IRQ_REQ);
        check("irq_indep", 32'h1, IRQ);
        apb(1'b1, `WDT_ADDR_IRQMASK, 32'h0, 1'b0);
        @(posedge CLK);
        #1;
        check("irq_masked", 32'h0, IRQ);
        wait_lvl(WDT_SYS_RESET, 1'b1, 1000);
        check("grace_len", 32'h1, (cyc - tt >= 508) && (cyc - tt <= 518));
        wait_lvl(WDT_SYS_RESET, 1'b0, 64);
        apb(1'b0, `WDT_ADDR_CTRL, 32'h0, 1'b0);
        check("ctrl_after", 32'h6, rd);
        apb(1'b0, `WDT_ADDR_IRQSTAT, 32'h0, 1'b0);
        check("status_sticky", 32'h3, rd[1:0]);
        apb(1'b1, `WDT_ADDR_IRQMASK, 32'h3, 1'b0);
        @(posedge CLK);
        #1;
        check("irq_unmasked", 32'h1, IRQ);
        apb(1'b1, `WDT_ADDR_IRQSTAT, 32'h3, 1'b0);
        apb(1'b0, `WDT_ADDR_IRQSTAT, 32'h0, 1'b0);
        check("status_clear", 32'h0, rd[1:0]);
        check("irq_cleared", 32'h0, IRQ);
        // Software clears the cause flag, enable held
        apb(1'b1, `WDT_ADDR_CTRL, 32'h0, 1'b0);
        apb(1'b0, `WDT_ADDR_CTRL, 32'h0, 1'b0);
        check("cause_clear", 32'h2, rd);
        POWER_FAIL_RESET <= 1'b1;
        repeat (4) @(posedge CLK);
        POWER_FAIL_RESET <= 1'b0;
        apb(1'b0, `WDT_ADDR_CTRL, 32'h0, 1'b0);
        check("ctrl_pfail", 32'h0, rd);
        test_done();
    end

    // Hang guard, well beyond one interval plus grace
    initial begin
        repeat (20000) @(posedge CLK);
        n_fail++;
        test_done();
    end
endmodule : tb_top
